// [rtl/fast_ethernet_rx_pcs.sv]
`timescale 1ns/1ps
module fast_ethernet_rx_pcs import fe_rx_pkg::*; #(
  parameter int HOLD_CYC = HOLD_CYCLES,
  parameter int LINK_CYC = LINK_CYCLES
) (
  // clock and reset
  input logic clock_i,
  input logic resetn_i,
  // line receiver side
  input logic line_clk_i,
  input line_sym_t line_sym_i,
  input logic signal_detect_i,
  // register port
  input logic [7:0] addr_i,
  input logic [31:0] wdata_i,
  input logic wr_i,
  input logic rd_i,
  output logic [31:0] rdata_o,
  // mac side
  output mii_rx_t mii_o,
  output logic [4:0] raw_sym_o,
  output logic link_up_o
);
  localparam logic [17:0] HOLD_LOAD = 18'(HOLD_CYC - 1);
  localparam logic [17:0] LINK_LAST = 18'(LINK_CYC - 1);

  logic sym_stb; // one cycle per received symbol
  line_sym_t sym;
  logic cru_locked;
  logic sd_s1; // first sync stage
  logic sd_s2;
  logic [31:0] cfg; // coding_sublayer_config_reg
  logic force_sd;
  logic sd_need_lock;
  logic descrambler_skip;
  logic symbol_decoder_skip;
  logic [31:0] status;
  logic nrzi;
  logic prev_nrzi;
  logic nrz;
  logic key;
  logic ud; // descrambled bit
  logic pbit; // bit into alignment
  logic [10:0] lfsr;
  logic locked;
  logic [5:0] match_cnt;
  logic [5:0] idle_run;
  logic [17:0] hold_cnt;
  logic refresh;
  logic expire;
  logic sd_ok;
  logic enter_ok;
  logic [17:0] link_cnt;
  logic link_up;
  logic run_ok;
  logic [9:0] sr; // last ten aligned-path bits
  logic [9:0] next_sr;
  logic [4:0] grp;
  logic [4:0] dec;
  logic [2:0] grp_bits; // bits of current group already held
  logic boundary;
  logic [3:0] ones_run;
  logic idle_ok;
  logic hunt_zero;
  rx_state_t state;
  logic ssd_k; // J seen, waiting for K
  logic ssd_bad;
  logic bad_evt;
  logic idle_grps;
  logic [3:0] held; // one group of delay for the preamble slot
  logic held_er;
  logic rx_clk;
  logic rx_dv;
  logic rx_er;
  logic [3:0] rxd;
  logic [15:0] fcc; // false carrier events

  // ----------------------------------------
  // clock recovery and signal detect sync
  // ----------------------------------------
  // recovered symbol timing
  clock_recovery_unit u_cru (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .line_clk_i(line_clk_i),
    .line_sym_i(line_sym_i),
    .sym_stb_o(sym_stb),
    .sym_o(sym),
    .locked_o(cru_locked)
  );

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sd_s1 <= 1'b0;
      sd_s2 <= 1'b0;
    end else begin
      sd_s1 <= signal_detect_i;
      sd_s2 <= sd_s1;
    end
  end

  // ----------------------------------------
  // register port
  // ----------------------------------------
  assign force_sd = cfg[CFG_FORCE_SD];
  assign sd_need_lock = cfg[CFG_SD_LOCK];
  assign descrambler_skip = cfg[CFG_DSCR_SKIP];
  assign symbol_decoder_skip = cfg[CFG_DEC_SKIP];

  // config write, reserved bits stay zero
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cfg <= CFG_RESET;
    end else if (wr_i && addr_i == OFS_CFG) begin
      cfg <= wdata_i & CFG_MASK;
    end
  end

  always_comb begin
    status = 32'h0;
    status[STS_LINK] = link_up;
    status[STS_LOCK] = locked;
    status[STS_CRU] = cru_locked;
    status[STS_SD] = sd_s2;
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_o <= 32'h0;
    end else if (rd_i) begin
      case (addr_i)
        OFS_CFG: rdata_o <= cfg;
        OFS_STATUS: rdata_o <= status;
        OFS_FCC: rdata_o <= {16'h0, fcc};
        default: rdata_o <= 32'h0;
      endcase
    end else begin
      rdata_o <= 32'h0;
    end
  end

  // ----------------------------------------
  // bit path
  // ----------------------------------------
  // nonzero level marks nrzi one
  assign nrzi = sym.pos | sym.neg;
  assign nrz = nrzi ^ prev_nrzi;
  // taps of x^11 + x^9 + 1
  assign key = lfsr[10] ^ lfsr[8];
  assign ud = nrz ^ key;
  assign pbit = descrambler_skip ? nrz : ud;

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      prev_nrzi <= 1'b0;
    end else if (sym_stb) begin
      prev_nrzi <= nrzi;
    end
  end

  // ----------------------------------------
  // descrambler lock and hold timer
  // ----------------------------------------
  // idle content refresh
  assign refresh = sym_stb & locked & ud & (idle_run == 6'(REFRESH_BITS - 1));
  assign expire = locked & ~refresh & (hold_cnt == 18'h0);

  // while unlocked the key is guessed from idle (plain ones), so
  // ~nrz is shifted in; a run of correct predictions proves the guess
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      lfsr <= 11'h000;
      locked <= 1'b0;
      match_cnt <= 6'h00;
      idle_run <= 6'h00;
      hold_cnt <= 18'h0;
    end else if (expire) begin
      locked <= 1'b0;
      lfsr <= 11'h000;
      match_cnt <= 6'h00;
      idle_run <= 6'h00;
    end else begin
      if (refresh) begin
        hold_cnt <= HOLD_LOAD;
      end else if (locked) begin
        hold_cnt <= hold_cnt - 18'h1;
      end
      if (sym_stb && locked) begin
        lfsr <= {lfsr[9:0], key};
        if (!ud || idle_run == 6'(REFRESH_BITS - 1)) begin
          idle_run <= 6'h00;
        end else begin
          idle_run <= idle_run + 6'h01;
        end
      end else if (sym_stb) begin
        lfsr <= {lfsr[9:0], ~nrz};
        if (~nrz == key) begin
          if (match_cnt == 6'(LOCK_BITS - 1)) begin
            locked <= 1'b1;
            hold_cnt <= HOLD_LOAD;
            match_cnt <= 6'h00;
          end else begin
            match_cnt <= match_cnt + 6'h01;
          end
        end else begin
          match_cnt <= 6'h00;
        end
      end
    end
  end

  // ----------------------------------------
  // link integrity monitor
  // ----------------------------------------
  // link pulses never lock the cru, so they cannot qualify detect
  assign sd_ok = force_sd | (sd_s2 & cru_locked);
  assign enter_ok = sd_ok & (~sd_need_lock | locked);

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      link_up <= 1'b0;
      link_cnt <= 18'h0;
    end else if (!sd_ok) begin
      link_up <= 1'b0;
      link_cnt <= 18'h0;
    end else if (!link_up) begin
      if (!enter_ok) begin
        link_cnt <= 18'h0;
      end else if (link_cnt == LINK_LAST) begin
        link_up <= 1'b1;
      end else begin
        link_cnt <= link_cnt + 18'h1;
      end
    end
  end

  assign link_up_o = link_up;

  // ----------------------------------------
  // serial to parallel and alignment
  // ----------------------------------------
  // decoder skip; decoding also waits for link up
  assign run_ok = link_up & (descrambler_skip | locked) & ~symbol_decoder_skip;
  assign next_sr = {sr[8:0], pbit};
  assign grp = next_sr[4:0];
  assign dec = decode_4b5b(grp);
  assign boundary = sym_stb & (grp_bits == 3'h4);
  assign idle_ok = (ones_run == IDLE_RUN_BITS);
  // first zero after idle is the third bit of J
  assign hunt_zero = run_ok & (state == RX_HUNT) & ~pbit & idle_ok;

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sr <= 10'h000;
      grp_bits <= 3'h0;
      raw_sym_o <= 5'h00;
    end else if (sym_stb) begin
      sr <= next_sr;
      if (hunt_zero) begin
        grp_bits <= 3'h3;
      end else if (grp_bits == 3'h4) begin
        grp_bits <= 3'h0;
        raw_sym_o <= grp;
      end else begin
        grp_bits <= grp_bits + 3'h1;
      end
    end
  end

  // consecutive ones, saturating at two idle groups
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ones_run <= 4'h0;
    end else if (sym_stb) begin
      if (!pbit) begin
        ones_run <= 4'h0;
      end else if (!idle_ok) begin
        ones_run <= ones_run + 4'h1;
      end
    end
  end

  // ----------------------------------------
  // receive state machine
  // ----------------------------------------
  // anything but J then K after idle
  assign ssd_bad = (state == RX_SSD) & boundary & (ssd_k ? grp != CG_K : grp != CG_J);
  assign bad_evt = run_ok & ssd_bad;

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state <= RX_HUNT;
      ssd_k <= 1'b0;
      idle_grps <= 1'b0;
      held <= 4'h0;
      held_er <= 1'b0;
      rx_dv <= 1'b0;
      rx_er <= 1'b0;
      rxd <= 4'h0;
    end else if (!run_ok) begin
      state <= RX_HUNT;
      rx_dv <= 1'b0;
      rx_er <= 1'b0;
      rxd <= 4'h0;
    end else if (sym_stb) begin
      case (state)
        RX_HUNT: begin
          if (hunt_zero) begin
            state <= RX_SSD;
            ssd_k <= 1'b0;
          end
        end
        RX_SSD: begin
          if (ssd_bad) begin
            state <= RX_BAD;
            idle_grps <= 1'b0;
            rx_er <= 1'b1;
            rxd <= NIB_FALSE_CARRIER;
          end else if (boundary && ssd_k) begin
            state <= RX_DATA;
            rx_dv <= 1'b1;
            rxd <= NIB_PREAMBLE;
            held <= NIB_PREAMBLE;
            held_er <= 1'b0;
          end else if (boundary) begin
            ssd_k <= 1'b1;
          end
        end
        RX_DATA: begin
          // lookup decode, stop at T or idle
          if (boundary) begin
            rxd <= held;
            rx_er <= held_er;
            held <= dec[3:0];
            held_er <= ~dec[4];
            if (grp == CG_T || grp == CG_IDLE) begin
              state <= RX_END;
            end
          end
        end
        RX_END: begin
          // second delimiter group closes the frame
          if (boundary) begin
            state <= RX_HUNT;
            rx_dv <= 1'b0;
            rx_er <= 1'b0;
            rxd <= 4'h0;
          end
        end
        RX_BAD: begin
          // hold error until two idle groups
          if (boundary) begin
            if (grp != CG_IDLE) begin
              idle_grps <= 1'b0;
            end else if (idle_grps) begin
              state <= RX_HUNT;
              rx_er <= 1'b0;
              rxd <= 4'h0;
            end else begin
              idle_grps <= 1'b1;
            end
          end
        end
        default: state <= RX_HUNT;
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fcc <= 16'h0000;
    end else if (bad_evt && fcc != 16'hffff) begin
      fcc <= fcc + 16'h0001;
    end
  end

  // receive clock from group phase
  // low for two symbols after data changes, so data is settled at rise
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rx_clk <= 1'b0;
    end else begin
      rx_clk <= (grp_bits >= 3'h2);
    end
  end

  assign mii_o = '{clk: rx_clk, dv: rx_dv, er: rx_er, rxd: rxd};

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_link_entry: assert property (
    @(posedge clock_i) disable iff (!resetn_i)
    $rose(link_up) |-> $past(link_cnt) == LINK_LAST && $past(enter_ok))
    else $error("link up before qualify time");
  a_link_lock: assert property (
    @(posedge clock_i) disable iff (!resetn_i)
    $rose(link_up) && $past(sd_need_lock) |-> $past(locked))
    else $error("link up without descrambler lock");
  a_link_stay: assert property (
    @(posedge clock_i) disable iff (!resetn_i) link_up && sd_ok |=> link_up)
    else $error("link dropped with signal detect present");
  a_link_drop: assert property (
    @(posedge clock_i) disable iff (!resetn_i) !sd_ok |=> !link_up && link_cnt == 18'h0)
    else $error("link kept without qualified detect");
  a_lock_entry: assert property (
    @(posedge clock_i) disable iff (!resetn_i)
    $rose(locked) |-> $past(match_cnt) == 6'(LOCK_BITS - 1) && $past(sym_stb))
    else $error("lock without twelve idle groups");
  a_hold_start: assert property (
    @(posedge clock_i) disable iff (!resetn_i) $rose(locked) |-> hold_cnt == HOLD_LOAD)
    else $error("hold timer not loaded at lock");
  a_hold_reload: assert property (
    @(posedge clock_i) disable iff (!resetn_i) refresh |=> hold_cnt == HOLD_LOAD && locked)
    else $error("idle content did not restart hold");
  a_hold_expire: assert property (
    @(posedge clock_i) disable iff (!resetn_i)
    locked && hold_cnt == 18'h0 && !refresh |=> !locked && lfsr == 11'h000)
    else $error("hold expiry kept lock");
  a_preamble_pair: assert property (
    @(posedge clock_i) disable iff (!resetn_i)
    run_ok && sym_stb && state == RX_SSD && boundary && ssd_k && !ssd_bad
    |=> rx_dv && rxd == NIB_PREAMBLE && held == NIB_PREAMBLE)
    else $error("J/K not replaced by preamble");
  a_bad_ssd: assert property (
    @(posedge clock_i) disable iff (!resetn_i) bad_evt && sym_stb |=> state == RX_BAD && rx_er)
    else $error("bad delimiter not flagged");
  a_false_nibble: assert property (
    @(posedge clock_i) disable iff (!resetn_i) rx_er && !rx_dv |-> rxd == NIB_FALSE_CARRIER)
    else $error("false carrier nibble wrong");
  a_fcc_step: assert property (
    @(posedge clock_i) disable iff (!resetn_i)
    bad_evt && fcc != 16'hffff |=> fcc == $past(fcc) + 16'h0001)
    else $error("false carrier count not one step");
  a_dec_skip: assert property (
    @(posedge clock_i) disable iff (!resetn_i) symbol_decoder_skip |=> !rx_dv && state == RX_HUNT)
    else $error("decoder active while skipped");

  c_lock: cover property (@(posedge clock_i) disable iff (!resetn_i) $rose(locked));
  c_link: cover property (@(posedge clock_i) disable iff (!resetn_i) $rose(link_up));
  c_frame: cover property (@(posedge clock_i) disable iff (!resetn_i)
    state == RX_END ##1 state == RX_HUNT);
  c_bad: cover property (@(posedge clock_i) disable iff (!resetn_i) bad_evt);
endmodule // fast_ethernet_rx_pcs

// [rtl/fe_rx_pkg.sv]
package fe_rx_pkg;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_MHZ = 250;
  localparam int HOLD_TIME_US = 722;
  localparam int HOLD_CYCLES = HOLD_TIME_US * CLK_MHZ;
  localparam int LINK_TIME_US = 395;
  localparam int LINK_CYCLES = LINK_TIME_US * CLK_MHZ;
  localparam int LOCK_BITS = 12 * 5;
  localparam int REFRESH_BITS = 58;
  localparam logic [3:0] IDLE_RUN_BITS = 4'ha;
  localparam logic [3:0] CRU_LOCK_EDGES = 4'h8;
  localparam logic [7:0] CRU_MAX_PERIOD = 8'hff;
  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [7:0] OFS_CFG = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_FCC = 8'h08;
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;
  localparam logic [31:0] CFG_MASK = 32'h0000_0132;
  localparam int CFG_FORCE_SD = 1;
  localparam int CFG_DSCR_SKIP = 4;
  localparam int CFG_DEC_SKIP = 5;
  localparam int CFG_SD_LOCK = 8;
  localparam int STS_LINK = 0;
  localparam int STS_LOCK = 1;
  localparam int STS_CRU = 2;
  localparam int STS_SD = 3;
  // ----------------------------------------
  // code groups and nibbles
  // ----------------------------------------
  localparam logic [4:0] CG_IDLE = 5'h1f;
  localparam logic [4:0] CG_J = 5'h18;
  localparam logic [4:0] CG_K = 5'h11;
  localparam logic [4:0] CG_T = 5'h0d;
  localparam logic [3:0] NIB_PREAMBLE = 4'h5;
  localparam logic [3:0] NIB_FALSE_CARRIER = 4'he;
  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [2:0] {
    RX_HUNT = 3'b000,
    RX_SSD = 3'b001,
    RX_DATA = 3'b010,
    RX_END = 3'b011,
    RX_BAD = 3'b100
  } rx_state_t;
  // one line symbol: positive or negative level, neither is zero
  typedef struct packed {
    logic pos;
    logic neg;
  } line_sym_t;
  typedef struct packed {
    logic clk;
    logic dv;
    logic er;
    logic [3:0] rxd;
  } mii_rx_t;
  // returns {valid, nibble} for a data code group
  function automatic logic [4:0] decode_4b5b(input logic [4:0] cg);
    case (cg)
      5'h1e: decode_4b5b = 5'h10;
      5'h09: decode_4b5b = 5'h11;
      5'h14: decode_4b5b = 5'h12;
      5'h15: decode_4b5b = 5'h13;
      5'h0a: decode_4b5b = 5'h14;
      5'h0b: decode_4b5b = 5'h15;
      5'h0e: decode_4b5b = 5'h16;
      5'h0f: decode_4b5b = 5'h17;
      5'h12: decode_4b5b = 5'h18;
      5'h13: decode_4b5b = 5'h19;
      5'h16: decode_4b5b = 5'h1a;
      5'h17: decode_4b5b = 5'h1b;
      5'h1a: decode_4b5b = 5'h1c;
      5'h1b: decode_4b5b = 5'h1d;
      5'h1c: decode_4b5b = 5'h1e;
      5'h1d: decode_4b5b = 5'h1f;
      default: decode_4b5b = 5'h00;
    endcase
  endfunction
endpackage

// [rtl/clock_recovery_unit.sv]
`timescale 1ns/1ps
module clock_recovery_unit import fe_rx_pkg::*; (
  // clock and reset
  input logic clock_i,
  input logic resetn_i,
  // line side
  input logic line_clk_i,
  input line_sym_t line_sym_i,
  // recovered symbol stream
  output logic sym_stb_o,
  output line_sym_t sym_o,
  output logic locked_o
);
  logic clk_s1; // first sync stage, read only by clk_s2
  logic clk_s2;
  logic clk_s3; // edge reference
  line_sym_t sym_s1;
  line_sym_t sym_s2;
  logic edge_hit;
  logic [7:0] per; // cycles since last edge
  logic [7:0] last_per;
  logic [3:0] good; // consecutive steady periods
  logic steady;

  // ----------------------------------------
  // synchronisers
  // ----------------------------------------
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      clk_s1 <= 1'b0;
      clk_s2 <= 1'b0;
      clk_s3 <= 1'b0;
      sym_s1 <= '0;
      sym_s2 <= '0;
    end else begin
      clk_s1 <= line_clk_i;
      clk_s2 <= clk_s1;
      clk_s3 <= clk_s2;
      sym_s1 <= line_sym_i;
      sym_s2 <= sym_s1;
    end
  end

  assign edge_hit = clk_s2 & ~clk_s3;
  assign steady = ({1'b0, per} + 9'h1 >= {1'b0, last_per}) &&
                  ({1'b0, per} <= {1'b0, last_per} + 9'h1);

  // symbol strobe
  // data is taken on the rising line edge, one strobe per symbol
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sym_stb_o <= 1'b0;
      sym_o <= '0;
    end else begin
      sym_stb_o <= edge_hit;
      if (edge_hit) begin
        sym_o <= sym_s2;
      end
    end
  end

  // digital lock tracking
  // lock needs a run of periods within one cycle of each other; sparse link pulses never get one
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      per <= 8'h00;
      last_per <= 8'h00;
      good <= 4'h0;
      locked_o <= 1'b0;
    end else if (edge_hit) begin
      per <= 8'h00;
      last_per <= per;
      if (!steady) begin
        good <= 4'h0;
        locked_o <= 1'b0;
      end else if (good == CRU_LOCK_EDGES) begin
        locked_o <= 1'b1;
      end else begin
        good <= good + 4'h1;
      end
    end else if (per == CRU_MAX_PERIOD) begin
      // line clock stopped: lose lock
      good <= 4'h0;
      locked_o <= 1'b0;
    end else begin
      per <= per + 8'h01;
    end
  end

  a_stb_single: assert property (
    @(posedge clock_i) disable iff (!resetn_i) sym_stb_o |=> !sym_stb_o)
    else $error("symbol strobe longer than one cycle");
endmodule // clock_recovery_unit

// [verif/mii_mac_model.sv]
`timescale 1ns/1ps
// ----------------------------------------
// mac receiver model
// ----------------------------------------
module mii_mac_model import fe_rx_pkg::*; (
  // clock and reset
  input logic clock_i,
  input logic resetn_i,
  // receive side from the phy
  input mii_rx_t mii_i,
  // one pulse per nibble taken: {er, rxd}
  output logic ev_o,
  output logic [4:0] ev_nib_o
);
  logic clk_d; // mii clock seen last cycle
  logic er_d; // error level at last mii clock rise
  // take data on mii clock rise, as a real mac would, two symbols into each group
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      clk_d <= 1'b0;
      er_d <= 1'b0;
      ev_o <= 1'b0;
      ev_nib_o <= 5'h00;
    end else begin
      clk_d <= mii_i.clk;
      ev_o <= 1'b0;
      if (mii_i.clk && !clk_d) begin
        er_d <= mii_i.er;
        // frame nibbles, or the start of a false carrier
        ev_o <= mii_i.dv || (mii_i.er && !er_d);
        ev_nib_o <= {mii_i.er, mii_i.rxd};
      end
    end
  end
endmodule // mii_mac_model

// [verif/tb_top.sv]
`timescale 1ns/1ps
module tb_top import fe_rx_pkg::*;;
  localparam logic [4:0] ENC [16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e, 5'h0f,
    5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d}; // nibble to code group
  logic clock_i = 0, resetn_i = 0, line_clk_i = 0, signal_detect_i = 1;
  logic wr_i = 0, rd_i = 0, rd_d = 0, link_up_o, ev;
  line_sym_t line_sym_i = '0;
  logic [7:0] addr_i = '0;
  logic [31:0] wdata_i = '0, rdata_o;
  mii_rx_t mii_o;
  logic [4:0] raw_sym_o, ev_nib;
  logic [10:0] scr = 11'h7ff; // line scrambler state
  logic [1:0] mlt = 2'd0; // three-level phase
  logic plain = 1'b0; // line sent without scrambling, for the skip mode
  logic [31:0] rnd = 32'he3a0;
  logic [4:0] mq [$]; // expected nibbles
  logic [31:0] rq [$]; // expected read data
  int error_cnt = 0, comparisons = 0, cyc = 0;
  // ----------------------------------------
  // design and mac
  // ----------------------------------------
  fast_ethernet_rx_pcs #(.HOLD_CYC(4000), .LINK_CYC(50)) dut (.clock_i(clock_i),
    .resetn_i(resetn_i), .line_clk_i(line_clk_i), .line_sym_i(line_sym_i),
    .signal_detect_i(signal_detect_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .mii_o(mii_o), .raw_sym_o(raw_sym_o),
    .link_up_o(link_up_o));
  mii_mac_model mac (.clock_i(clock_i), .resetn_i(resetn_i), .mii_i(mii_o), .ev_o(ev),
    .ev_nib_o(ev_nib));
  initial begin
    forever #2 clock_i = ~clock_i;
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic end_of_test();
    error_cnt += mq.size() + rq.size(); // results that never came
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rq.push_back(e);
    @(posedge clock_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
  endtask
  // symbols change on the line clock fall, half a period from its rise
  task automatic tx_bit(input logic b);
    logic k;
    k = scr[10] ^ scr[8];
    scr = {scr[9:0], k};
    if (b ^ (k & ~plain)) mlt = mlt + 2'd1;
    line_sym_i = '{pos: mlt == 2'd1, neg: mlt == 2'd3};
    #62.5 line_clk_i = 1'b1;
    #62.5 line_clk_i = 1'b0;
  endtask
  task automatic tx_grp(input logic [4:0] g);
    for (int i = 4; i >= 0; i--) tx_bit(g[i]);
  endtask
  task automatic idle(input int n);
    repeat (n) tx_grp(CG_IDLE);
  endtask
  task automatic frame();
    logic [3:0] n;
    tx_grp(CG_J);
    tx_grp(CG_K);
    mq.push_back(5'h05);
    mq.push_back(5'h05);
    repeat (4) begin
      n = rnd[3:0];
      rnd = lfsr(rnd);
      mq.push_back({1'b0, n});
      tx_grp(ENC[n]);
    end
    tx_grp(CG_T);
    tx_grp(5'h07);
  endtask
  // ----------------------------------------
  // result watcher and hang guard
  // ----------------------------------------
  always @(posedge clock_i) begin
    cyc++;
    if (rd_d) chk("rdata", rq.size() ? rq.pop_front() : 32'hdead, rdata_o);
    rd_d <= rd_i;
    if (ev) chk("mii", mq.size() ? {27'h0, mq.pop_front()} : 32'hbad, {27'h0, ev_nib});
    if (cyc == 35000) begin
      error_cnt++;
      end_of_test();
    end
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (6) @(posedge clock_i);
    resetn_i <= 1'b1;
    rd(OFS_CFG, CFG_RESET);
    wr(OFS_CFG, rnd);
    rd(OFS_CFG, rnd & CFG_MASK);
    rnd = lfsr(rnd);
    wr(OFS_STATUS, rnd);
    rd(8'h0c, 32'h0);
    wr(OFS_CFG, 32'h100);
    idle(40);
    // reads run beside the stream: a gap in the line clock would break lock
    fork
      rd(OFS_STATUS, 32'hf);
      frame();
    join
    idle(12);
    mq.push_back(5'h1e);
    tx_grp(ENC[4]);
    idle(12);
    fork
      rd(OFS_FCC, 32'h1);
      frame();
    join
    idle(12);
    mq.push_back(5'h1e);
    // no idle content long enough for the hold timer to run out
    repeat (32) tx_grp(5'h15);
    fork
      begin
        rd(OFS_STATUS, 32'hd);
        rd(OFS_FCC, 32'h2);
        wr(OFS_CFG, 32'h10);
      end
      begin
        // unscrambled line while the descrambler is skipped
        plain = 1'b1;
        idle(20);
        frame();
        fork
          idle(4);
          begin
            @(posedge clock_i);
            signal_detect_i <= 1'b0;
            repeat (8) @(posedge clock_i);
            rd(OFS_STATUS, 32'h6);
            chk("link", 32'h0, {31'h0, link_up_o});
            wr(OFS_CFG, 32'h12);
            repeat (60) @(posedge clock_i);
            rd(OFS_STATUS, 32'h7);
          end
        join
      end
    join
    chk("raw", 32'h1f, {27'h0, raw_sym_o});
    repeat (4) @(posedge clock_i);
    end_of_test();
  end
endmodule // tb_top
